/* bench/board_model.sv */
`timescale 1ns/1ps
// -------------------------------------------------------------
// Board reset circuit and coprocessor busy line
// -------------------------------------------------------------
module board_model
   (
   input wire logic sys_clk,
   input wire logic hold_low,
   input wire logic [1:0] strap_mode,
   input wire logic strap_pull_en,
   input wire logic reset_out,
   output logic init_request_n,
   output logic strap_in
   );
   logic [3:0] low_cnt_reg = 4'h0;
   logic req_n_reg = 1'b0;
   logic float_reg = 1'b0;
   // Request released only after the low time is met
   // low time enforced
   always @(posedge sys_clk)
   begin
      float_reg <= ~float_reg;
      if (hold_low)
      begin
         req_n_reg <= 1'b0;
         low_cnt_reg <= (low_cnt_reg == 4'hF) ? 4'hF : low_cnt_reg + 4'h1;
      end
      else if (low_cnt_reg >= 4'hA)
      begin
         req_n_reg <= 1'b1;
         low_cnt_reg <= 4'h0;
      end
   end
   assign init_request_n = req_n_reg;
   // Strap: 0 released, 1 tied to reset, 2 low, 3 high; unpulled float wanders
   // strap and busy drive
   always_comb
   begin
      case (strap_mode)
         2'h0: strap_in = strap_pull_en ? 1'b1 : float_reg;
         2'h1: strap_in = reset_out;
         2'h2: strap_in = 1'b0;
         default: strap_in = 1'b1;
      endcase
   end
endmodule // board_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import reset_clock_mode_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic hold_low = 1'b1;
   logic [1:0] strap_mode = 2'h0;
   logic bus_hold = 1'b0;
   logic wait_start = 1'b0;
   logic int_enable = 1'b0;
   logic irq_pending = 1'b0;
   logic init_request_n, strap_in, system_clock_out, reset_out, fetch_start, enhanced_mode;
   logic strap_as_input, strap_pull_en, wait_stall, wait_irq_service, fpu_ready;
   int errors = 0;
   int n_tests = 0;
   int seed = 32'h0b27;
   int n;
   int i;
   always #2.5 sys_clk = ~sys_clk;
   // -------------------------------------------------------------
   // Instances
   // -------------------------------------------------------------
   reset_clock_mode_strap DUT (.sys_clk(sys_clk), .arst_n(arst_n), .init_request_n(init_request_n),
      .strap_in(strap_in), .bus_hold(bus_hold), .wait_start(wait_start), .int_enable(int_enable),
      .irq_pending(irq_pending), .system_clock_out(system_clock_out), .reset_out(reset_out),
      .fetch_start(fetch_start), .enhanced_mode(enhanced_mode), .strap_as_input(strap_as_input),
      .strap_pull_en(strap_pull_en), .wait_stall(wait_stall), .wait_irq_service(wait_irq_service),
      .fpu_ready(fpu_ready));
   board_model partner (.sys_clk(sys_clk), .hold_low(hold_low), .strap_mode(strap_mode),
      .strap_pull_en(strap_pull_en), .reset_out(reset_out), .init_request_n(init_request_n),
      .strap_in(strap_in));
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
         errors++;
      end
   endtask
   // Only a strap that follows the reset output falls in time for enhanced mode
   function logic [7:0] exp_mode(input logic [1:0] m);
      return (m == 2'h1) ? 8'h1 : 8'h0;
   endfunction
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task pulse_wait;
      @(posedge sys_clk);
      wait_start <= 1'b1;
      @(posedge sys_clk);
      wait_start <= 1'b0;
   endtask
   // Hold a request, release it and follow the start-up sequence
   task boot(input logic [1:0] m, input int len);
      logic prev;
      hold_low <= 1'b1;
      strap_mode <= m;
      @(posedge sys_clk);
      prev = system_clock_out;
      repeat (len)
      begin
         @(posedge sys_clk);
         bus_hold <= 1'($random(seed));
         chk("clock toggle", {7'h0, ~prev}, 8'(system_clock_out));
         prev = system_clock_out;
      end
      chk("reset held", 8'h1, 8'(reset_out));
      hold_low <= 1'b0;
      n = 0;
      while (reset_out !== 1'b0 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      // Partner adds one edge, tick alignment one more
      chk("release delay", 8'h1, 8'(n >= 8 && n <= 10));
      n = 0;
      while (fetch_start !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("fetch delay", 8'(FETCH_DELAY_CYC - RESET_RELEASE_CYC), 8'(n));
      @(posedge sys_clk);
      chk("fetch pulse", 8'h0, 8'(fetch_start));
      chk("mode", exp_mode(m), 8'(enhanced_mode));
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("strap input", 8'h1, 8'(strap_as_input));
      chk("pull-up", 8'h1, 8'(strap_pull_en));
      for (i = 0; i < 4; i++)
         boot(i[1:0], 12 + ($random(seed) & 15));
      hold_low <= 1'b1;
      repeat (12) @(posedge sys_clk);
      hold_low <= 1'b0;
      repeat (7) @(posedge sys_clk);
      hold_low <= 1'b1;
      n = 0;
      repeat (14)
      begin
         @(posedge sys_clk);
         if (fetch_start === 1'b1)
            n++;
      end
      chk("abort reset", 8'h1, 8'(reset_out));
      chk("abort fetch", 8'h0, 8'(n));
      boot(2'h3, 12);
      int_enable <= 1'b1;
      irq_pending <= 1'b1;
      pulse_wait();
      repeat (3) @(posedge sys_clk);
      chk("stall", 8'h1, 8'(wait_stall));
      chk("irq in stall", 8'h1, 8'(wait_irq_service));
      // Count every edge since the stall was taken, random dwell included
      n = 3;
      i = $random(seed) & 31;
      repeat (i)
      begin
         @(posedge sys_clk);
         n++;
      end
      strap_mode <= 2'h2;
      while (wait_stall !== 1'b0 && n < 200)
      begin
         @(posedge sys_clk);
         n++;
      end
      // Resume is seen one edge past a poll point
      chk("poll phase", 8'h1, 8'(n % WAIT_POLL_CYC));
      pulse_wait();
      repeat (4) @(posedge sys_clk);
      chk("low strap no stall", 8'h0, 8'(wait_stall));
      boot(2'h1, 12);
      chk("ready", 8'h1, 8'(fpu_ready));
      strap_mode <= 2'h3;
      pulse_wait();
      repeat (4) @(posedge sys_clk);
      chk("busy", 8'h0, 8'(fpu_ready));
      chk("no wait enhanced", 8'h0, 8'(wait_stall));
      conclude();
   end
   // Runaway guard, far beyond the few hundred cycles needed
   initial
   begin
      #50000;
      errors++;
      conclude();
   end
endmodule // tb_top

/* hw/pin_sync.sv */
`timescale 1ns/1ps
// Two-stage (or deeper) synchroniser for one pin
module pin_sync
   #(parameter int STAGES = 2,
     parameter logic RESET_VAL = 1'h0)
   (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic pin_in,
   output logic pin_sync_out
   );

   logic [STAGES-1:0] chain_reg;
   logic [STAGES-1:0] chain_next;

   // -----------------------------------------------------------------
   // Parameter check
   // -----------------------------------------------------------------
   if (STAGES < 2)
   begin : g_bad_stages
      $error("pin_sync needs at least two stages");
   end

   // -----------------------------------------------------------------
   // Shift chain
   // -----------------------------------------------------------------
   // First stage feeds only the second, nothing else looks at it
   always_comb
   begin
      chain_next = {chain_reg[STAGES-2:0], pin_in};
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         chain_reg <= {STAGES{RESET_VAL}};
      else
         chain_reg <= chain_next;
   end

   assign pin_sync_out = chain_reg[STAGES-1];

endmodule // pin_sync

/* hw/reset_clock_mode_pkg.sv */
package reset_clock_mode_pkg;

   // -----------------------------------------------------------------
   // Clock division
   // -----------------------------------------------------------------
   // Oscillator cycles per system clock period
   localparam int OSC_DIV = 2;

   // -----------------------------------------------------------------
   // Sequence timing, in system clock periods
   // -----------------------------------------------------------------
   localparam int RESET_RELEASE_CLKS = 2;
   localparam int STRAP_CHECK_CLKS = 4;
   localparam int WAIT_POLL_CLKS = 5;
   // Fetch start sits 6.5 clocks after release, kept in half clocks
   localparam int FETCH_DELAY_HALF_CLKS = 13;

   // -----------------------------------------------------------------
   // Derived counts in oscillator cycles
   // -----------------------------------------------------------------
   localparam int CNT_W = 4;
   localparam int RESET_RELEASE_CYC = RESET_RELEASE_CLKS * OSC_DIV;
   localparam int STRAP_CHECK_CYC = STRAP_CHECK_CLKS * OSC_DIV;
   localparam int WAIT_POLL_CYC = WAIT_POLL_CLKS * OSC_DIV;
   localparam int FETCH_DELAY_CYC = FETCH_DELAY_HALF_CLKS * OSC_DIV / 2;
   localparam logic [CNT_W-1:0] REL_END = CNT_W'(RESET_RELEASE_CYC - 1);
   localparam logic [CNT_W-1:0] STRAP_END = CNT_W'(STRAP_CHECK_CYC - 1);
   localparam logic [CNT_W-1:0] FETCH_END = CNT_W'(FETCH_DELAY_CYC - 1);
   localparam logic [CNT_W-1:0] POLL_END = CNT_W'(WAIT_POLL_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   // Synchroniser reset levels: request held active, strap pulled up
   localparam logic INIT_SYNC_RST = 1'h0;
   localparam logic STRAP_SYNC_RST = 1'h1;

   // -----------------------------------------------------------------
   // Reset sequence states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ST_RESET, ST_RELEASE, ST_RUN} seq_state_type;

endpackage

/* hw/reset_clock_mode_strap.sv */
// Notes on behaviour
// - Reset output is active high, clock aligned, and lasts as long as the request.
// - Reset output falls 2 system clocks after the request release is synchronised and clock aligned.
// - Reset output stays driven during bus hold.
// - System clock is the oscillator divided by two.
// - System clock has 50% duty and runs through reset and bus hold.
// - An active request at once clears all activity and holds the block dormant; it is synchronised.
// - Instruction fetch starts about 6.5 clocks after the request is released.
// - Enhanced mode needs the strap high at release and low four clocks later; else compatible.
// - The strap is made an input while reset is active, with a weak pull-up.
// - In compatible mode a wait instruction stalls if the strap is high.
// - A stalled wait resamples the strap every five clocks and resumes when low.
// - Enabled interrupts are still serviced during a wait stall.
// - In enhanced mode the strap is an active-high coprocessor busy input for float instructions.
`timescale 1ns/1ps
module reset_clock_mode_strap
   import reset_clock_mode_pkg::*;
   (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic init_request_n,
   input wire logic strap_in,
   input wire logic bus_hold,
   input wire logic wait_start,
   input wire logic int_enable,
   input wire logic irq_pending,
   output logic system_clock_out,
   output logic reset_out,
   output logic fetch_start,
   output logic enhanced_mode,
   output logic strap_as_input,
   output logic strap_pull_en,
   output logic wait_stall,
   output logic wait_irq_service,
   output logic fpu_ready
   );

   logic init_sync;
   logic strap_sync;
   logic tick;
   seq_state_type state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [CNT_W-1:0] poll_reg, poll_next;
   logic phase_reg, phase_next;
   logic reset_out_reg, reset_out_next;
   logic fetch_reg, fetch_next;
   logic enhanced_reg, enhanced_next;
   logic strap_first_reg, strap_first_next;
   logic strap_input_reg, strap_input_next;
   logic pull_reg, pull_next;
   logic stall_reg, stall_next;
   logic irq_svc_reg, irq_svc_next;
   logic fpu_ready_reg, fpu_ready_next;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // two stages each
   pin_sync #(.STAGES(2), .RESET_VAL(INIT_SYNC_RST)) u_init_sync
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .pin_in(init_request_n),
      .pin_sync_out(init_sync)
   );

   pin_sync #(.STAGES(2), .RESET_VAL(STRAP_SYNC_RST)) u_strap_sync
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .pin_in(strap_in),
      .pin_sync_out(strap_sync)
   );

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Tick marks the system clock falling edge, one cycle in two
   assign tick = phase_reg;

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      poll_next = poll_reg;
      reset_out_next = reset_out_reg;
      enhanced_next = enhanced_reg;
      strap_first_next = strap_first_reg;
      strap_input_next = strap_input_reg;
      stall_next = stall_reg;
      fetch_next = 1'b0;
      // divide by two, toggling every oscillator cycle
      // never gated, so duty stays 50% in reset and hold
      phase_next = ~phase_reg;
      pull_next = 1'b1;
      unique case (state_reg)
         ST_RESET:
         begin
            // held high for the whole request
            reset_out_next = 1'b1;
            // configure strap as input while reset is active
            strap_input_next = 1'b1;
            // Release only on a tick so the count stays clock aligned
            if (init_sync && tick)
            begin
               state_next = ST_RELEASE;
               cnt_next = CNT_ZERO;
               // first strap sample at the request's rising edge
               strap_first_next = strap_sync;
            end
         end
         ST_RELEASE:
         begin
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == REL_END)
               reset_out_next = 1'b0;
            // a tied-back reset output is low by then
            if (cnt_reg == STRAP_END)
               enhanced_next = strap_first_reg & ~strap_sync;
            // fetch begins 6.5 clocks after release
            if (cnt_reg == FETCH_END)
            begin
               fetch_next = 1'b1;
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (!stall_reg)
            begin
               // compatible mode wait stalls on a high strap
               if (wait_start && !enhanced_reg && strap_sync)
               begin
                  stall_next = 1'b1;
                  poll_next = CNT_ZERO;
               end
            end
            else
            begin
               poll_next = poll_reg + CNT_ONE;
               if (poll_reg == POLL_END)
               begin
                  poll_next = CNT_ZERO;
                  if (!strap_sync)
                     stall_next = 1'b0;
               end
            end
         end
      endcase
      // active request abandons everything at once
      if (!init_sync)
      begin
         state_next = ST_RESET;
         reset_out_next = 1'b1;
         stall_next = 1'b0;
         enhanced_next = 1'b0;
         fetch_next = 1'b0;
      end
      // interrupts still serviced during the stall
      irq_svc_next = stall_next & int_enable & irq_pending;
      // busy high blocks a new coprocessor command
      fpu_ready_next = ~(enhanced_next & strap_sync);
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_RESET;
         cnt_reg <= CNT_ZERO;
         poll_reg <= CNT_ZERO;
         phase_reg <= 1'b0;
         reset_out_reg <= 1'b1;
         fetch_reg <= 1'b0;
         enhanced_reg <= 1'b0;
         strap_first_reg <= 1'b0;
         strap_input_reg <= 1'b0;
         pull_reg <= 1'b0;
         stall_reg <= 1'b0;
         irq_svc_reg <= 1'b0;
         fpu_ready_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         poll_reg <= poll_next;
         phase_reg <= phase_next;
         reset_out_reg <= reset_out_next;
         fetch_reg <= fetch_next;
         enhanced_reg <= enhanced_next;
         strap_first_reg <= strap_first_next;
         strap_input_reg <= strap_input_next;
         pull_reg <= pull_next;
         stall_reg <= stall_next;
         irq_svc_reg <= irq_svc_next;
         fpu_ready_reg <= fpu_ready_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // reset output has no enable, so bus hold cannot float it
   assign reset_out = reset_out_reg;
   assign system_clock_out = phase_reg;
   assign fetch_start = fetch_reg;
   assign enhanced_mode = enhanced_reg;
   assign strap_as_input = strap_input_reg;
   assign strap_pull_en = pull_reg;
   assign wait_stall = stall_reg;
   assign wait_irq_service = irq_svc_reg;
   assign fpu_ready = fpu_ready_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // Skip the edge right after reset, where the divider has only just started
   clock_toggles_a: assert property ($past(arst_n) |-> system_clock_out != $past(system_clock_out))
      else $error("system clock failed to toggle");

   clock_duty_a: assert property ($rose(system_clock_out) |=> $fell(system_clock_out))
      else $error("system clock high phase not one cycle");

   // A new request inside the first two clocks keeps the output high
   reset_release_a: assert property ($rose(state_reg == ST_RELEASE)
      |-> reset_out[*4] ##1 (!reset_out || state_reg == ST_RESET))
      else $error("reset output fell at the wrong time");

   reset_follows_a: assert property (!init_sync |=> reset_out && state_reg == ST_RESET)
      else $error("reset output not asserted during request");

   hold_driven_a: assert property (bus_hold && state_reg == ST_RESET |=> reset_out)
      else $error("reset output lost during bus hold");

   dormant_clear_a: assert property (!init_sync |=> !wait_stall && !fetch_start && !enhanced_mode)
      else $error("activity not cleared by request");

   fetch_delay_a: assert property ($rose(state_reg == ST_RELEASE) && init_sync
      |-> ##13 (fetch_start || state_reg == ST_RESET))
      else $error("fetch start not at 6.5 clocks");

   mode_strap_a: assert property ($rose(state_reg == ST_RELEASE) ##8 (state_reg != ST_RESET)
      |-> enhanced_mode == ($past(strap_first_reg) && !$past(strap_sync)))
      else $error("mode chosen from wrong strap samples");

   wait_stall_a: assert property (state_reg == ST_RUN && !wait_stall && wait_start && !enhanced_mode && strap_sync
      && init_sync |=> wait_stall)
      else $error("wait did not stall on high strap");

   wait_resume_a: assert property ($fell(wait_stall) && $past(init_sync)
      |-> $past(poll_reg) == POLL_END && !$past(strap_sync))
      else $error("wait resumed off the poll point");

   // Service tracks the stall, so it drops together with a resume
   irq_service_a: assert property (wait_stall && int_enable && irq_pending && init_sync
      |=> wait_irq_service == wait_stall)
      else $error("interrupt ignored during wait");

   busy_block_a: assert property (enhanced_mode && strap_sync && init_sync |=> !fpu_ready)
      else $error("coprocessor issue allowed while busy");

   pullup_on_a: assert property ($past(arst_n) |-> strap_pull_en)
      else $error("strap pull-up not enabled");

endmodule // reset_clock_mode_strap
